/* seq_pkg.sv */
// Shared constants and types of the start-up and fault sequencer.
// Assumes a 200 MHz device clock; the timer, sequencer and test files refer to names here.
package seq_pkg;

  // Register offsets on the settings port.
  localparam logic [7:0] CFG_A_ADDR = 8'hd2;
  localparam logic [7:0] CFG_B_ADDR = 8'hd3;
  localparam logic [7:0] DELAY_ADDR = 8'hd4;
  localparam logic [7:0] TRIM_ADDR = 8'he2;
  localparam logic [7:0] PG_HI_ADDR = 8'hd8;
  localparam logic [7:0] PG_LO_ADDR = 8'hd9;
  localparam logic [7:0] STATUS_ADDR = 8'hda;

  // Field positions and widths.
  localparam int LATCH_EN_BIT = 1;
  localparam int DELAY_CODE_W = 3;
  localparam int TRIM_W = 5;

  // Reset values.
  localparam logic [7:0] CFG_RST = 8'h02;
  localparam logic [7:0] DELAY_RST = 8'h03;
  localparam logic [7:0] TRIM_RST = 8'h0f;
  localparam logic [7:0] PG_HI_RST = 8'h80;
  localparam logic [7:0] PG_LO_RST = 8'h40;

  // Timing: figures in ns, cycle counts derived from the clock period.
  localparam int CLK_PERIOD_NS = 5;
  localparam int DELAY_UNIT_NS = 500000;
  localparam int BLANK_NS = 100000;
  localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCHOFF_MULT = 4;
  localparam int CNT_W = 24;

  typedef enum logic [7:0] {
    ST_OFF = 8'h01,
    ST_TD1 = 8'h02,
    ST_RAMP_BOOT = 8'h04,
    ST_TD3 = 8'h08,
    ST_RAMP_VID = 8'h10,
    ST_TD5 = 8'h20,
    ST_RUN = 8'h40,
    ST_LATCHED = 8'h80
  } seq_state_t;

endpackage : seq_pkg

/* interval_timer.sv */
// Single programmable delay timer shared by start-up intervals and latch-off.
// Assumes start, abort and code are synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
  parameter int UNIT_CYC = seq_pkg::DELAY_UNIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic i_long,
  input wire logic [seq_pkg::DELAY_CODE_W-1:0] i_code,
  output logic o_busy,
  output logic o_done
);

  typedef struct packed {
    logic [seq_pkg::CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } tmr_t;

  tmr_t tmr_reg;
  tmr_t tmr_next;

  if (UNIT_CYC < 1 || UNIT_CYC * 32 >= (1 << seq_pkg::CNT_W)) begin : g_bad_unit
    $error("UNIT_CYC out of range for the timer counter");
  end

  // Interval length: (code+1) units, four times that for latch-off.
  function automatic logic [seq_pkg::CNT_W-1:0] load_count(input logic [2:0] code, input logic long_t);
    logic [seq_pkg::CNT_W-1:0] base;
    base = seq_pkg::CNT_W'((int'(code) + 1) * UNIT_CYC);
    load_count = long_t ? seq_pkg::CNT_W'(base * seq_pkg::LATCHOFF_MULT) : base;
  endfunction : load_count

  always_comb begin
    tmr_next = tmr_reg;
    tmr_next.done = 1'b0;
    if (i_abort) begin
      tmr_next.busy = 1'b0;
      tmr_next.cnt = '0;
    end else if (i_start) begin
      tmr_next.busy = 1'b1;
      tmr_next.cnt = load_count(i_code, i_long) - seq_pkg::CNT_W'(1);
    end else if (tmr_reg.busy) begin
      if (tmr_reg.cnt == '0) begin
        tmr_next.busy = 1'b0;
        tmr_next.done = 1'b1;
      end else begin
        tmr_next.cnt = tmr_reg.cnt - seq_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tmr_reg <= '0;
    end else if (i_ce) begin
      tmr_reg <= tmr_next;
    end
  end

  assign o_busy = tmr_reg.busy;
  assign o_done = tmr_reg.done;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  timer_load_a: assert property ((i_start && !i_abort && i_ce) |=>
    (tmr_reg.cnt == load_count($past(i_code), $past(i_long)) - seq_pkg::CNT_W'(1)) && tmr_reg.busy)
    else $error("Timer did not load the programmed interval");
  timer_done_a: assert property (o_done |-> $past(tmr_reg.busy) && $past(tmr_reg.cnt) == '0)
    else $error("Timer finished before its count ran out");

endmodule : interval_timer
`default_nettype wire

/* startup_fault_sequencer.sv */
// Start-up sequencer, over-current latch-off, power-good, phase shedding and crowbar.
// Assumes comparator results arrive synchronous to i_clk and settings come over a byte port.
//
// Contract
// - Start-up delay is (3-bit code + 1) times 0.5 ms.
// - After reset the delay code is 011, giving 2 ms.
// - One timer times the first, third and fifth start-up intervals.
// - Over-current latch-off lasts four times the programmed start-up delay.
// - A 5-bit trim scales the over-current threshold from 50% in 3.3% steps.
// - Latch-off timing starts only on current limit after the fifth interval.
// - Current limit during start-up does not stop the five start-up intervals.
// - Phases keep switching while timing; clearing resumes, expiry latches shut down.
// - Supply loss or a brief enable low clears a latched shutdown.
// - With latch enable clear in both configs the device never latches off.
// - During start-up below 200 mV the control voltage is clamped to 1.5 V; clamped here only in the boot ramp, third interval and VID ramp.
// - Power-good low when out of range, no processor code, or enable low.
// - Out-of-range is ignored by power-good for 100 us after a code change.
// - Power-good held low until soft-start done and fifth interval complete.
// - Software holds upper and lower power-good window limits.
// - Low-power-state input low drives the shed-phase disable output low.
// - Overvoltage forces phases low until the output falls below about 300 mV.
// - Crowbar threshold follows the programmed upper power-good limit.
// - Start only with supply OK and enable; either dropping disables the device.
// - Disabled holds phases, power-good and both driver disables low.
// - Each voltage code change restarts the power-good and crowbar blanking.
`timescale 1ns/1ps
`default_nettype none
module startup_fault_sequencer #(
  parameter int DELAY_UNIT_CYC = seq_pkg::DELAY_UNIT_CYC,
  parameter int BLANK_CYC = seq_pkg::BLANK_CYC,
  parameter int VCODE_W = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_enable,
  input wire logic i_supply_undervoltage_lockout_ok,
  input wire logic i_ss_boot_done,
  input wire logic i_ss_done,
  input wire logic i_overcurrent,
  input wire logic i_above_upper_limit,
  input wire logic i_below_lower_limit,
  input wire logic i_below_release,
  input wire logic i_below_200mv,
  input wire logic i_no_cpu_code,
  input wire logic [VCODE_W-1:0] i_voltage_code,
  input wire logic i_low_power_state_in_n,
  output logic [7:0] o_reg_rdata,
  output logic o_phase_enable,
  output logic o_power_good_out,
  output logic o_shed_phase_disable_out_n,
  output logic o_fixed_phase_disable_out_n,
  output logic o_secondary_clamp,
  output logic o_crowbar,
  output logic o_latched_off,
  output logic [seq_pkg::TRIM_W-1:0] o_ocp_trim,
  output logic [7:0] o_pg_upper_limit,
  output logic [7:0] o_pg_lower_limit
);

  if (BLANK_CYC < 1 || BLANK_CYC >= (1 << seq_pkg::CNT_W) || VCODE_W < 1) begin : g_bad_param
    $error("BLANK_CYC or VCODE_W out of range");
  end

  typedef struct packed {
    seq_pkg::seq_state_t state;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] delay_sel;
    logic [7:0] trim;
    logic [7:0] pg_hi;
    logic [7:0] pg_lo;
    logic [7:0] rdata;
    logic [VCODE_W-1:0] vcode_prev;
    logic [seq_pkg::CNT_W-1:0] blank_cnt;
    logic ocp_timing;
    logic crowbar;
    logic pg;
    logic phase_en;
    logic shed_n;
    logic fixed_n;
    logic clamp;
    logic latched;
  } seq_t;

  localparam seq_t SEQ_RST = '{
    state: seq_pkg::ST_OFF,
    cfg_a: seq_pkg::CFG_RST,
    cfg_b: seq_pkg::CFG_RST,
    delay_sel: seq_pkg::DELAY_RST,
    trim: seq_pkg::TRIM_RST,
    pg_hi: seq_pkg::PG_HI_RST,
    pg_lo: seq_pkg::PG_LO_RST,
    rdata: 8'h00,
    vcode_prev: '0,
    blank_cnt: '0,
    ocp_timing: 1'b0,
    crowbar: 1'b0,
    pg: 1'b0,
    phase_en: 1'b0,
    shed_n: 1'b0,
    fixed_n: 1'b0,
    clamp: 1'b0,
    latched: 1'b0
  };

  seq_t seq_reg;
  seq_t seq_next;

  logic tmr_start;
  logic tmr_abort;
  logic tmr_long;
  logic tmr_busy;
  logic tmr_done;
  logic active;
  logic blanking;
  logic out_of_range;
  logic latch_en;

  interval_timer #(
    .UNIT_CYC(DELAY_UNIT_CYC)
  ) u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_start(tmr_start),
    .i_abort(tmr_abort),
    .i_long(tmr_long),
    .i_code(seq_reg.delay_sel[seq_pkg::DELAY_CODE_W-1:0]),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // Status byte: one-hot sequence state.
  function automatic logic [7:0] read_mux(input seq_t s, input logic [7:0] addr);
    case (addr)
      seq_pkg::CFG_A_ADDR: read_mux = s.cfg_a;
      seq_pkg::CFG_B_ADDR: read_mux = s.cfg_b;
      seq_pkg::DELAY_ADDR: read_mux = {5'h00, s.delay_sel[2:0]};
      seq_pkg::TRIM_ADDR: read_mux = {3'h0, s.trim[4:0]};
      seq_pkg::PG_HI_ADDR: read_mux = s.pg_hi;
      seq_pkg::PG_LO_ADDR: read_mux = s.pg_lo;
      seq_pkg::STATUS_ADDR: read_mux = s.state;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  always_comb begin
    seq_next = seq_reg;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_long = 1'b0;
    active = i_enable & i_supply_undervoltage_lockout_ok;
    // The change cycle itself is blanked, so an excursion that comes with the step is masked too.
    blanking = (seq_reg.blank_cnt != '0) || (i_voltage_code != seq_reg.vcode_prev);
    out_of_range = i_above_upper_limit | i_below_lower_limit;
    latch_en = seq_reg.cfg_a[seq_pkg::LATCH_EN_BIT] | seq_reg.cfg_b[seq_pkg::LATCH_EN_BIT];

    if (i_reg_wr) begin
      case (i_reg_addr)
        seq_pkg::CFG_A_ADDR: seq_next.cfg_a = i_reg_wdata;
        seq_pkg::CFG_B_ADDR: seq_next.cfg_b = i_reg_wdata;
        seq_pkg::DELAY_ADDR: seq_next.delay_sel = {5'h00, i_reg_wdata[2:0]};
        seq_pkg::TRIM_ADDR: seq_next.trim = {3'h0, i_reg_wdata[4:0]};
        seq_pkg::PG_HI_ADDR: seq_next.pg_hi = i_reg_wdata;
        seq_pkg::PG_LO_ADDR: seq_next.pg_lo = i_reg_wdata;
        default: seq_next.rdata = seq_reg.rdata;
      endcase
    end
    seq_next.rdata = read_mux(seq_reg, i_reg_addr);

    // A code change reloads the blanking window; it then counts down.
    seq_next.vcode_prev = i_voltage_code;
    if (i_voltage_code != seq_reg.vcode_prev) begin
      seq_next.blank_cnt = seq_pkg::CNT_W'(BLANK_CYC);
    end else if (blanking) begin
      seq_next.blank_cnt = seq_reg.blank_cnt - seq_pkg::CNT_W'(1);
    end

    case (seq_reg.state)
      seq_pkg::ST_OFF: begin
        if (active) begin
          seq_next.state = seq_pkg::ST_TD1;
          tmr_start = 1'b1;
        end
      end
      seq_pkg::ST_TD1: begin
        if (tmr_done) begin
          seq_next.state = seq_pkg::ST_RAMP_BOOT;
        end
      end
      seq_pkg::ST_RAMP_BOOT: begin
        if (i_ss_boot_done) begin
          seq_next.state = seq_pkg::ST_TD3;
          tmr_start = 1'b1;
        end
      end
      seq_pkg::ST_TD3: begin
        if (tmr_done) begin
          seq_next.state = seq_pkg::ST_RAMP_VID;
        end
      end
      seq_pkg::ST_RAMP_VID: begin
        if (i_ss_done) begin
          seq_next.state = seq_pkg::ST_TD5;
          tmr_start = 1'b1;
        end
      end
      seq_pkg::ST_TD5: begin
        // Over-current here is not acted on until the interval ends.
        if (tmr_done) begin
          seq_next.state = seq_pkg::ST_RUN;
        end
      end
      seq_pkg::ST_RUN: begin
        if (seq_reg.ocp_timing) begin
          if (!i_overcurrent || !latch_en) begin
            tmr_abort = 1'b1;
            seq_next.ocp_timing = 1'b0;
          end else if (tmr_done) begin
            seq_next.state = seq_pkg::ST_LATCHED;
            seq_next.ocp_timing = 1'b0;
          end
        end else if (i_overcurrent && latch_en) begin
          tmr_start = 1'b1;
          tmr_long = 1'b1;
          seq_next.ocp_timing = 1'b1;
        end
      end
      seq_pkg::ST_LATCHED: begin
        seq_next.state = seq_pkg::ST_LATCHED;
      end
      default: begin
        seq_next.state = seq_pkg::ST_OFF;
      end
    endcase

    if (!active) begin
      seq_next.state = seq_pkg::ST_OFF;
      seq_next.ocp_timing = 1'b0;
      tmr_start = 1'b0;
      tmr_abort = 1'b1;
    end

    // Crowbar trips on the upper limit comparator, outside blanking; trip beats release.
    if (!active || seq_reg.state == seq_pkg::ST_OFF) begin
      seq_next.crowbar = 1'b0;
    end else if (i_above_upper_limit && !blanking) begin
      seq_next.crowbar = 1'b1;
    end else if (i_below_release) begin
      seq_next.crowbar = 1'b0;
    end

    seq_next.fixed_n = !(seq_next.state inside {seq_pkg::ST_OFF, seq_pkg::ST_LATCHED});
    seq_next.shed_n = seq_next.fixed_n && i_low_power_state_in_n;
    seq_next.phase_en = seq_next.state inside {seq_pkg::ST_RAMP_BOOT, seq_pkg::ST_TD3, seq_pkg::ST_RAMP_VID,
      seq_pkg::ST_TD5, seq_pkg::ST_RUN} && !seq_next.crowbar;
    seq_next.pg = seq_next.state == seq_pkg::ST_RUN && i_enable && !i_no_cpu_code && !seq_next.crowbar &&
      (!out_of_range || blanking);
    seq_next.clamp = seq_next.state inside {seq_pkg::ST_RAMP_BOOT, seq_pkg::ST_TD3, seq_pkg::ST_RAMP_VID} &&
      i_below_200mv;
    seq_next.latched = seq_next.state == seq_pkg::ST_LATCHED;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      seq_reg <= SEQ_RST;
    end else if (i_ce) begin
      seq_reg <= seq_next;
    end
  end

  assign o_reg_rdata = seq_reg.rdata;
  assign o_phase_enable = seq_reg.phase_en;
  assign o_power_good_out = seq_reg.pg;
  assign o_shed_phase_disable_out_n = seq_reg.shed_n;
  assign o_fixed_phase_disable_out_n = seq_reg.fixed_n;
  assign o_secondary_clamp = seq_reg.clamp;
  assign o_crowbar = seq_reg.crowbar;
  assign o_latched_off = seq_reg.latched;
  assign o_ocp_trim = seq_reg.trim[seq_pkg::TRIM_W-1:0];
  assign o_pg_upper_limit = seq_reg.pg_hi;
  assign o_pg_lower_limit = seq_reg.pg_lo;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  reset_delay_a: assert property ($past(i_sys_rst) |-> seq_reg.delay_sel == seq_pkg::DELAY_RST)
    else $error("Delay code not at its reset value");
  disabled_outputs_a: assert property ((!(i_enable && i_supply_undervoltage_lockout_ok) && i_ce) |=>
    !o_phase_enable && !o_power_good_out && !o_shed_phase_disable_out_n && !o_fixed_phase_disable_out_n)
    else $error("Outputs not held low while disabled");
  ocp_start_run_a: assert property ((tmr_start && tmr_long) |-> seq_reg.state == seq_pkg::ST_RUN)
    else $error("Latch-off timing started before start-up completed");
  startup_ocp_a: assert property ((seq_reg.state == seq_pkg::ST_TD5 && tmr_done && active && i_ce) |=>
    seq_reg.state == seq_pkg::ST_RUN)
    else $error("Start-up did not complete under current limit");
  latch_cause_a: assert property ($rose(o_latched_off) |-> $past(latch_en) && $past(tmr_done))
    else $error("Latched off without enable or expiry");
  latch_hold_a: assert property ((o_latched_off && active && i_ce) |=>
    o_latched_off && !o_phase_enable && !o_power_good_out)
    else $error("Latched shutdown released without a clearing event");
  latch_clear_a: assert property ((o_latched_off && !i_enable && i_ce) |=> !o_latched_off)
    else $error("Enable low did not clear latched shutdown");
  pg_blank_a: assert property ((o_power_good_out && $past(i_ce) && $past(out_of_range)) |->
    $past(blanking))
    else $error("Power-good high while out of range and not blanked");
  pg_run_a: assert property (o_power_good_out |-> seq_reg.state == seq_pkg::ST_RUN)
    else $error("Power-good high before start-up finished");
  shed_low_a: assert property ((!i_low_power_state_in_n && i_ce) |=> !o_shed_phase_disable_out_n)
    else $error("Shed-phase disable not low in low-power state");
  crowbar_phase_a: assert property (o_crowbar |-> !o_phase_enable)
    else $error("Phases enabled during crowbar");
  clamp_cause_a: assert property (o_secondary_clamp |-> $past(i_below_200mv))
    else $error("Secondary clamp without low output");
  blank_restart_a: assert property (((i_voltage_code != seq_reg.vcode_prev) && i_ce) |=>
    seq_reg.blank_cnt == seq_pkg::CNT_W'(BLANK_CYC))
    else $error("Code change did not restart blanking");
  latch_disabled_a: assert property ((!latch_en && !o_latched_off && i_ce) |=> !o_latched_off)
    else $error("Latched off with latch enable clear");
  pg_enable_a: assert property ((!i_enable && i_ce) |=> !o_power_good_out)
    else $error("Power-good high with enable low");
  pg_no_cpu_a: assert property ((i_no_cpu_code && i_ce) |=> !o_power_good_out)
    else $error("Power-good high with no processor code");
  crowbar_blank_a: assert property ($rose(o_crowbar) |-> !$past(blanking))
    else $error("Crowbar tripped inside the blanking window");
  crowbar_release_a: assert property ((o_crowbar && i_below_release && !i_above_upper_limit && i_ce) |=>
    !o_crowbar)
    else $error("Crowbar not released below the release level");
  ce_freeze_a: assert property (!i_ce |=> $stable(seq_reg))
    else $error("State changed while clock enable was low");

  run_reached_c: cover property ($rose(seq_reg.state == seq_pkg::ST_RUN));
  latched_c: cover property ($rose(o_latched_off));
  crowbar_c: cover property ($rose(o_crowbar));
  ocp_recover_c: cover property (seq_reg.ocp_timing && tmr_abort && active);

endmodule : startup_fault_sequencer
`default_nettype wire

/* load_model.sv */
// Behavioural output stage and load: soft-start ramp and crowbar discharge.
// Assumes phase enable and crowbar come from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module load_model #(
  parameter int RAMP_LEN = 12
) (
  input wire logic i_clk,
  input wire logic i_phase_enable,
  input wire logic i_crowbar,
  output logic o_ss_boot_done,
  output logic o_ss_done,
  output logic o_below_200mv,
  output logic o_below_release
);
  int ramp_reg = 0;
  int drain_reg = 0;
  // The ramp only climbs while phases switch, and the crowbar drains the output.
  always_ff @(posedge i_clk) begin
    ramp_reg <= (i_phase_enable && !i_crowbar) ? ((ramp_reg < RAMP_LEN) ? ramp_reg + 1 : ramp_reg) : 0;
    drain_reg <= i_crowbar ? drain_reg + 1 : 0;
  end
  assign o_below_200mv = ramp_reg < 3;
  assign o_ss_boot_done = ramp_reg >= RAMP_LEN / 3;
  assign o_ss_done = ramp_reg == RAMP_LEN;
  assign o_below_release = drain_reg >= 6;
endmodule : load_model
`default_nettype wire

/* startup_fault_sequencer_test.sv */
// Self-checking bench for the start-up and fault sequencer with a behavioural load.
// Assumes short timing parameters so each timed start-up interval lasts 4 to 32 cycles.
`timescale 1ns/1ps
`default_nettype none
module startup_fault_sequencer_test;
  localparam int UNIT = 4;
  localparam int BLANK = 3;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1, i_reg_wr = 1'b0, i_enable = 1'b0, i_supply_undervoltage_lockout_ok = 1'b1;
  logic i_overcurrent = 1'b0, i_above_upper_limit = 1'b0, i_below_lower_limit = 1'b0, i_no_cpu_code = 1'b0;
  logic i_low_power_state_in_n = 1'b1;
  logic [7:0] i_reg_addr = seq_pkg::STATUS_ADDR, i_reg_wdata = 8'h00, i_voltage_code = 8'h30;
  logic i_ss_boot_done, i_ss_done, i_below_release, i_below_200mv;
  logic [7:0] o_reg_rdata, o_pg_upper_limit, o_pg_lower_limit, rd_val, rv;
  logic [4:0] o_ocp_trim;
  logic o_phase_enable, o_power_good_out, o_shed_phase_disable_out_n, o_fixed_phase_disable_out_n;
  logic o_secondary_clamp, o_crowbar, o_latched_off;
  int bad_count = 0, checked = 0, seed = 32'heea7, code, off;
  logic [7:0] regs [8] = '{seq_pkg::CFG_A_ADDR, seq_pkg::CFG_B_ADDR, seq_pkg::DELAY_ADDR, seq_pkg::TRIM_ADDR,
                           seq_pkg::STATUS_ADDR, 8'h77, seq_pkg::PG_HI_ADDR, seq_pkg::PG_LO_ADDR};
  logic [7:0] vals [8] = '{8'h02, 8'h02, 8'h03, 8'h0f, 8'h01, 8'h00, seq_pkg::PG_HI_RST, seq_pkg::PG_LO_RST};

  startup_fault_sequencer #(.DELAY_UNIT_CYC(UNIT), .BLANK_CYC(BLANK), .VCODE_W(8)) startup_fault_sequencer_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_enable(i_enable), .i_supply_undervoltage_lockout_ok(i_supply_undervoltage_lockout_ok), .i_ss_boot_done(i_ss_boot_done),
    .i_ss_done(i_ss_done), .i_overcurrent(i_overcurrent), .i_above_upper_limit(i_above_upper_limit),
    .i_below_lower_limit(i_below_lower_limit), .i_below_release(i_below_release), .i_below_200mv(i_below_200mv),
    .i_no_cpu_code(i_no_cpu_code), .i_voltage_code(i_voltage_code), .i_low_power_state_in_n(i_low_power_state_in_n),
    .o_reg_rdata(o_reg_rdata), .o_phase_enable(o_phase_enable), .o_power_good_out(o_power_good_out),
    .o_shed_phase_disable_out_n(o_shed_phase_disable_out_n), .o_fixed_phase_disable_out_n(o_fixed_phase_disable_out_n),
    .o_secondary_clamp(o_secondary_clamp), .o_crowbar(o_crowbar), .o_latched_off(o_latched_off),
    .o_ocp_trim(o_ocp_trim), .o_pg_upper_limit(o_pg_upper_limit), .o_pg_lower_limit(o_pg_lower_limit));

  load_model #(.RAMP_LEN(12)) load_model_i (.i_clk(i_clk), .i_phase_enable(o_phase_enable), .i_crowbar(o_crowbar),
    .o_ss_boot_done(i_ss_boot_done), .o_ss_done(i_ss_done), .o_below_200mv(i_below_200mv),
    .o_below_release(i_below_release));

  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  function automatic int span(input int c);
    return (c + 1) * UNIT;
  endfunction : span

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    tick(1);
    i_reg_wr = 1'b0;
    i_reg_addr = seq_pkg::STATUS_ADDR;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    i_reg_addr = a;
    tick(1);
    d = o_reg_rdata;
    i_reg_addr = seq_pkg::STATUS_ADDR;
    tick(1);
  endtask : rd

  task automatic wait_state(input logic [7:0] st, input int bound);
    int k;
    k = 0;
    while (o_reg_rdata !== st && k < bound) begin
      tick(1);
      k++;
    end
    if (o_reg_rdata !== st) begin
      check("state reached", st, o_reg_rdata);
      give_verdict();
    end
  endtask : wait_state

  // Counts the cycles the status shows one state; the read lag cancels out.
  task automatic measure(input logic [7:0] st, input int exp, input int slack);
    int k;
    wait_state(st, 40 * UNIT);
    k = 0;
    while (o_reg_rdata === st && k < 300) begin
      tick(1);
      k++;
    end
    check("state duration in range", 8'h01, 8'(k >= exp && k <= exp + slack));
  endtask : measure

  task automatic start_up(input int c);
    i_enable = 1'b1;
    measure(8'h02, span(c), 3);
    check("clamp in ramp", 8'h01, {7'h0, o_secondary_clamp});
    measure(8'h08, span(c), 3);
    measure(8'h20, span(c), 3);
    check("state run", 8'h40, o_reg_rdata);
    check("power good and clamp", 8'h02, {6'h0, o_power_good_out, o_secondary_clamp});
  endtask : start_up

  task automatic stop();
    i_enable = 1'b0;
    tick(2);
    check("state off", 8'h01, o_reg_rdata);
    check("disabled outputs", 8'h00, {4'h0, o_phase_enable, o_power_good_out, o_shed_phase_disable_out_n,
      o_fixed_phase_disable_out_n});
  endtask : stop

  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    foreach (regs[k]) begin
      rd(regs[k], rd_val);
      check("reset register", vals[k], rd_val);
    end
    rv = 8'($random(seed));
    wr(seq_pkg::TRIM_ADDR, rv);
    check("trim field", {3'h0, rv[4:0]}, {3'h0, o_ocp_trim});
    $display("test registers done");
    off = $random(seed);
    for (int k = 0; k < 8; k++) begin
      code = (k + off) & 7;
      wr(seq_pkg::DELAY_ADDR, {5'($random(seed)), 3'(code)});
      rd(seq_pkg::DELAY_ADDR, rd_val);
      check("delay code", 8'(code), rd_val);
      start_up(code);
      stop();
    end
    $display("test start-up intervals done");
    i_overcurrent = 1'b1;
    start_up(code);
    measure(8'h40, 4 * span(code), 4);
    check("latched state", 8'h80, o_reg_rdata);
    check("latched outputs", 8'h08, {4'h0, o_latched_off, o_phase_enable, o_power_good_out,
      o_fixed_phase_disable_out_n});
    i_overcurrent = 1'b0;
    tick(10);
    check("latch holds", 8'h80, o_reg_rdata);
    i_enable = 1'b0;
    tick(1);
    start_up(code);
    $display("test latch-off done");
    i_overcurrent = 1'b1;
    tick(2 * span(code));
    check("phases switch in limit", 8'h01, {7'h0, o_phase_enable});
    i_overcurrent = 1'b0;
    tick(4 * span(code));
    check("resumed run", 8'h40, o_reg_rdata);
    wr(seq_pkg::CFG_A_ADDR, 8'h00);
    wr(seq_pkg::CFG_B_ADDR, 8'h00);
    i_overcurrent = 1'b1;
    tick(4 * span(code) + 12);
    check("no latch when disabled", 8'h40, o_reg_rdata);
    i_overcurrent = 1'b0;
    i_low_power_state_in_n = 1'b0;
    tick(2);
    check("low power disables", 8'h01, {6'h0, o_shed_phase_disable_out_n, o_fixed_phase_disable_out_n});
    i_low_power_state_in_n = 1'b1;
    tick(2);
    check("full power", 8'h03, {6'h0, o_shed_phase_disable_out_n, o_fixed_phase_disable_out_n});
    $display("test over-current and phase shed done");
    i_voltage_code = i_voltage_code + 8'(1 + ($random(seed) & 7));
    i_below_lower_limit = 1'b1;
    tick(1);
    check("power good blanked", 8'h01, {7'h0, o_power_good_out});
    tick(BLANK + 3);
    check("power good out of range", 8'h00, {7'h0, o_power_good_out});
    i_below_lower_limit = 1'b0;
    i_no_cpu_code = 1'b1;
    tick(3);
    check("power good no processor", 8'h00, {7'h0, o_power_good_out});
    i_no_cpu_code = 1'b0;
    tick(3);
    check("power good back", 8'h01, {7'h0, o_power_good_out});
    rv = 8'($random(seed));
    wr(seq_pkg::PG_HI_ADDR, rv);
    check("upper limit", rv, o_pg_upper_limit);
    wr(seq_pkg::PG_LO_ADDR, ~rv);
    check("lower limit", ~rv, o_pg_lower_limit);
    i_voltage_code = i_voltage_code + 8'h01;
    i_above_upper_limit = 1'b1;
    tick(1);
    check("crowbar blanked", 8'h00, {7'h0, o_crowbar});
    tick(BLANK + 3);
    check("crowbar trips", 8'h02, {6'h0, o_crowbar, o_phase_enable});
    i_above_upper_limit = 1'b0;
    tick(12);
    check("crowbar released", 8'h01, {6'h0, o_crowbar, o_phase_enable});
    $display("test power good and crowbar done");
    i_supply_undervoltage_lockout_ok = 1'b0;
    tick(2);
    check("undervoltage off", 8'h01, o_reg_rdata);
    check("undervoltage outputs", 8'h00, {5'h0, o_phase_enable, o_power_good_out, o_fixed_phase_disable_out_n});
    i_supply_undervoltage_lockout_ok = 1'b1;
    wait_state(8'h02, 5);
    check("restart", 8'h02, o_reg_rdata);
    stop();
    i_ce = 1'b0;
    i_enable = 1'b1;
    tick(4);
    check("frozen by clock enable", 8'h01, o_reg_rdata);
    check("frozen outputs", 8'h00, {7'h0, o_fixed_phase_disable_out_n});
    i_ce = 1'b1;
    wait_state(8'h02, 5);
    check("resume after clock enable", 8'h02, o_reg_rdata);
    stop();
    $display("test enable and undervoltage done");
    give_verdict();
  end
endmodule : startup_fault_sequencer_test
`default_nettype wire
